// file: inc/afb_defines.vh
// constants for the auxiliary flag word bank: offsets, field positions, timing
// assumes a plain register port with 4-bit word addresses and 16-bit data
//
// Overview of operation
// - word 0 bit 11 is set while the communications unit reports an error
// - word 2 bits 0-7 hold the last network operation completion code
// - word 2 bit 8 is set when a network operation ended in error
// - word 2 bit 9 is set while a new network operation may be issued
// - word 2 bit 15 is set while a communications unit is mounted
// - word 3 holds last scan's unit servicing time, 4-digit BCD, 0.1 ms units
// - word 4 low byte holds the slot 1 inner-board error code
// - word 4 high byte holds the slot 2 inner-board error code
// - combined mode: counter reset bit one enables index-phase reset
// - software-only mode: reset bit rising executes software reset
// - comparison bit rising starts range comparison of that counter
// - comparison bit falling stops range comparison of that counter
// - counter stop bit one halts the counter, zero keeps it counting
// - word 6 bits 0-3 force external outputs 1-4 on
// - word 6 bit 4 gates the four force-set bits
// - status words 0, 2, 3 and 4 are refreshed once per scan cycle; words 1, 5-8 read back live
// - special-area error flag mirrors the word 0 error flag exactly
`ifndef AFB_DEFINES_VH
`define AFB_DEFINES_VH

`define AFB_ADDR_W 4
`define AFB_DATA_W 16

`define AFB_OFS_ERR 4'h0
`define AFB_OFS_RESTART 4'h1
`define AFB_OFS_NET 4'h2
`define AFB_OFS_SVC 4'h3
`define AFB_OFS_SLOT 4'h4
`define AFB_OFS_CNT 4'h5
`define AFB_OFS_FORCE 4'h6
`define AFB_OFS_IRQ_STAT 4'h7
`define AFB_OFS_IRQ_MASK 4'h8

`define AFB_BIT_COMM_ERR 11
`define AFB_BIT_RESTART 11
`define AFB_NET_CODE_HI 7
`define AFB_NET_CODE_LO 0
`define AFB_BIT_NET_ERR 8
`define AFB_BIT_NET_EN 9
`define AFB_BIT_MOUNTED 15
`define AFB_CNT_RST_LO 0
`define AFB_CNT_CMP_LO 8
`define AFB_CNT_STOP_LO 12
`define AFB_BIT_FORCE_EN 4

`define AFB_CNT_MASK 16'hff0f
`define AFB_FORCE_MASK 16'h001f
`define AFB_RESET_WORD 16'h0000

`define AFB_IRQ_COMM_ERR 0
`define AFB_IRQ_NET_DONE 1
`define AFB_IRQ_NET_ERR 2
`define AFB_IRQ_MOUNT 3
`define AFB_IRQ_SLOT_ERR 4
`define AFB_IRQ_W 5

`define AFB_CLK_NS 5
`define AFB_SVC_UNIT_NS 100000
// clk cycles in one 0.1 ms unit at 5 ns, sized to the 15-bit divider
`define AFB_SVC_CYCLES 15'd20000
`define AFB_SVC_CNT_W 15
`define AFB_BCD_MAX 16'h9999

`endif

// file: logic/afb_bank.v
// auxiliary flag and control word bank with scan-cycle refresh
// assumes scan_tick is a one-cycle pulse from the scan controller on clk;
// comm unit level pins are asynchronous, other inputs come from clk logic
`timescale 1ns/1ps
`include "afb_defines.vh"

module afb_bank #(
  parameter [`AFB_SVC_CNT_W-1:0] SVC_CYCLES = `AFB_SVC_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // register port
  input wire [`AFB_ADDR_W-1:0] reg_addr,
  input wire [`AFB_DATA_W-1:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [`AFB_DATA_W-1:0] reg_rdata,
  // scan cycle
  input wire scan_tick,
  // communications unit pins
  input wire comm_error_pin,
  input wire comm_mounted_pin,
  input wire comm_busy_pin,
  output reg comm_restart,
  output reg special_comm_error,
  // network operation results
  input wire net_done,
  input wire net_failed,
  input wire [7:0] net_code,
  input wire net_ready,
  // inner board error codes
  input wire [7:0] slot1_code,
  input wire [7:0] slot2_code,
  // counter board
  input wire [3:0] counter_sw_only,
  output reg [3:0] counter_index_reset_en,
  output reg [3:0] counter_sw_reset,
  output reg [3:0] compare_start,
  output reg [3:0] compare_stop,
  output reg [3:0] counter_halt,
  output reg [3:0] ext_force_on,
  // interrupt
  output reg irq
);

  // one BCD digit step with carry out
  function [4:0] bcd_digit_inc;
    input [3:0] d;
    input cin;
    begin
      if (!cin)
        bcd_digit_inc = {1'b0, d};
      else if (d == 4'h9)
        bcd_digit_inc = {1'b1, 4'h0};
      else
        bcd_digit_inc = {1'b0, d + 4'h1};
    end
  endfunction

  // four-digit BCD increment, holds at 9999 rather than wrap
  function [15:0] bcd_inc;
    input [15:0] v;
    reg [4:0] d0;
    reg [4:0] d1;
    reg [4:0] d2;
    reg [4:0] d3;
    begin
      d0 = bcd_digit_inc(v[3:0], 1'b1);
      d1 = bcd_digit_inc(v[7:4], d0[4]);
      d2 = bcd_digit_inc(v[11:8], d1[4]);
      d3 = bcd_digit_inc(v[15:12], d2[4]);
      if (v == `AFB_BCD_MAX)
        bcd_inc = v;
      else
        bcd_inc = {d3[3:0], d2[3:0], d1[3:0], d0[3:0]};
    end
  endfunction

  // pin synchronisers
  reg [2:0] pin_meta;
  reg [2:0] pin_sync;
  wire comm_error_s = pin_sync[0];
  wire comm_mounted_s = pin_sync[1];
  wire comm_busy_s = pin_sync[2];

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end
    else
    begin
      pin_meta <= {comm_busy_pin, comm_mounted_pin, comm_error_pin};
      pin_sync <= pin_meta;
    end
  end

  // software-written words
  reg restart_bit;
  reg [15:0] cnt_ctrl;
  reg [15:0] force_ctrl;
  reg [`AFB_IRQ_W-1:0] irq_mask;
  reg [`AFB_IRQ_W-1:0] irq_stat;

  // copies applied at the last scan refresh
  reg restart_app;
  reg [15:0] cnt_app;

  // published status words
  reg comm_err_word;
  reg [7:0] net_code_word;
  reg net_err_word;
  reg net_en_word;
  reg mounted_word;
  reg [15:0] svc_word;
  reg [15:0] slot_word;

  // pending network result, published at the next refresh
  reg net_pend;
  reg net_pend_err;
  reg [7:0] net_pend_code;

  // servicing time accumulation
  reg [`AFB_SVC_CNT_W-1:0] svc_div;
  reg [15:0] svc_acc;

  wire wr_restart = reg_write && (reg_addr == `AFB_OFS_RESTART);
  wire wr_cnt = reg_write && (reg_addr == `AFB_OFS_CNT);
  wire wr_force = reg_write && (reg_addr == `AFB_OFS_FORCE);
  wire wr_mask = reg_write && (reg_addr == `AFB_OFS_IRQ_MASK);
  wire wr_stat = reg_write && (reg_addr == `AFB_OFS_IRQ_STAT);

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      restart_bit <= 1'b0;
      cnt_ctrl <= `AFB_RESET_WORD;
      force_ctrl <= `AFB_RESET_WORD;
      irq_mask <= {`AFB_IRQ_W{1'b0}};
    end
    else
    begin
      if (wr_restart)
        restart_bit <= reg_wdata[`AFB_BIT_RESTART];
      if (wr_cnt)
        cnt_ctrl <= reg_wdata & `AFB_CNT_MASK;
      if (wr_force)
        force_ctrl <= reg_wdata & `AFB_FORCE_MASK;
      if (wr_mask)
        irq_mask <= reg_wdata[`AFB_IRQ_W-1:0];
    end
  end

  // latch network results between refreshes so a short pulse is not missed
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      net_pend <= 1'b0;
      net_pend_err <= 1'b0;
      net_pend_code <= 8'h00;
    end
    else if (net_done)
    begin
      net_pend <= 1'b1;
      net_pend_err <= net_failed;
      net_pend_code <= net_code;
    end
    else if (scan_tick)
      net_pend <= 1'b0;
  end

  // servicing time: count 0.1 ms units while the unit is being serviced
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      svc_div <= {`AFB_SVC_CNT_W{1'b0}};
      svc_acc <= 16'h0000;
    end
    else if (scan_tick)
    begin
      svc_div <= {`AFB_SVC_CNT_W{1'b0}};
      svc_acc <= 16'h0000;
    end
    else if (comm_busy_s)
    begin
      if (svc_div == SVC_CYCLES - 1'b1)
      begin
        svc_div <= {`AFB_SVC_CNT_W{1'b0}};
        svc_acc <= bcd_inc(svc_acc);
      end
      else
        svc_div <= svc_div + 1'b1;
    end
  end

  // scan refresh of status words and application of control words
  wire [3:0] rst_new = cnt_ctrl[`AFB_CNT_RST_LO+3:`AFB_CNT_RST_LO];
  wire [3:0] rst_old = cnt_app[`AFB_CNT_RST_LO+3:`AFB_CNT_RST_LO];
  wire [3:0] cmp_new = cnt_ctrl[`AFB_CNT_CMP_LO+3:`AFB_CNT_CMP_LO];
  wire [3:0] cmp_old = cnt_app[`AFB_CNT_CMP_LO+3:`AFB_CNT_CMP_LO];

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      restart_app <= 1'b0;
      cnt_app <= `AFB_RESET_WORD;
      comm_err_word <= 1'b0;
      special_comm_error <= 1'b0;
      net_code_word <= 8'h00;
      net_err_word <= 1'b0;
      net_en_word <= 1'b0;
      mounted_word <= 1'b0;
      svc_word <= 16'h0000;
      slot_word <= 16'h0000;
      comm_restart <= 1'b0;
      counter_index_reset_en <= 4'h0;
      counter_sw_reset <= 4'h0;
      compare_start <= 4'h0;
      compare_stop <= 4'h0;
      counter_halt <= 4'h0;
      ext_force_on <= 4'h0;
    end
    else
    begin
      comm_restart <= 1'b0;
      counter_sw_reset <= 4'h0;
      compare_start <= 4'h0;
      compare_stop <= 4'h0;
      if (scan_tick)
      begin
        comm_err_word <= comm_error_s;
        special_comm_error <= comm_error_s;
        mounted_word <= comm_mounted_s;
        net_en_word <= net_ready;
        if (net_pend)
        begin
          net_code_word <= net_pend_code;
          net_err_word <= net_pend_err;
        end
        // final unit not folded in: last partial 0.1 ms is truncated
        svc_word <= svc_acc;
        slot_word <= {slot2_code, slot1_code};
        restart_app <= restart_bit;
        comm_restart <= restart_app & ~restart_bit;
        cnt_app <= cnt_ctrl;
        counter_index_reset_en <= rst_new & ~counter_sw_only;
        counter_sw_reset <= rst_new & ~rst_old & counter_sw_only;
        compare_start <= cmp_new & ~cmp_old;
        compare_stop <= ~cmp_new & cmp_old;
        counter_halt <= cnt_ctrl[`AFB_CNT_STOP_LO+3:`AFB_CNT_STOP_LO];
        ext_force_on <= force_ctrl[3:0] & {4{force_ctrl[`AFB_BIT_FORCE_EN]}};
      end
    end
  end

  // interrupt events, each raised at a refresh
  reg [`AFB_IRQ_W-1:0] irq_evt;

  always @*
  begin
    irq_evt = {`AFB_IRQ_W{1'b0}};
    if (scan_tick)
    begin
      irq_evt[`AFB_IRQ_COMM_ERR] = comm_error_s & ~comm_err_word;
      irq_evt[`AFB_IRQ_NET_DONE] = net_pend;
      irq_evt[`AFB_IRQ_NET_ERR] = net_pend & net_pend_err;
      irq_evt[`AFB_IRQ_MOUNT] = comm_mounted_s ^ mounted_word;
      irq_evt[`AFB_IRQ_SLOT_ERR] = ({slot2_code, slot1_code} != 16'h0000) &&
        (slot_word == 16'h0000);
    end
  end

  // set wins over a write-one clear in the same cycle
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_stat <= {`AFB_IRQ_W{1'b0}};
      irq <= 1'b0;
    end
    else
    begin
      if (wr_stat)
        irq_stat <= (irq_stat & ~reg_wdata[`AFB_IRQ_W-1:0]) | irq_evt;
      else
        irq_stat <= irq_stat | irq_evt;
      irq <= |(((wr_stat ? (irq_stat & ~reg_wdata[`AFB_IRQ_W-1:0]) : irq_stat) | irq_evt)
        & (wr_mask ? reg_wdata[`AFB_IRQ_W-1:0] : irq_mask));
    end
  end

  // read port, data in the cycle after the strobe, unmapped reads zero
  reg [15:0] rd_mux;

  always @*
  begin
    rd_mux = 16'h0000;
    case (reg_addr)
      `AFB_OFS_ERR: rd_mux[`AFB_BIT_COMM_ERR] = comm_err_word;
      `AFB_OFS_RESTART: rd_mux[`AFB_BIT_RESTART] = restart_bit;
      `AFB_OFS_NET:
      begin
        rd_mux[`AFB_NET_CODE_HI:`AFB_NET_CODE_LO] = net_code_word;
        rd_mux[`AFB_BIT_NET_ERR] = net_err_word;
        rd_mux[`AFB_BIT_NET_EN] = net_en_word;
        rd_mux[`AFB_BIT_MOUNTED] = mounted_word;
      end
      `AFB_OFS_SVC: rd_mux = svc_word;
      `AFB_OFS_SLOT: rd_mux = slot_word;
      `AFB_OFS_CNT: rd_mux = cnt_ctrl;
      `AFB_OFS_FORCE: rd_mux = force_ctrl;
      `AFB_OFS_IRQ_STAT: rd_mux[`AFB_IRQ_W-1:0] = irq_stat;
      `AFB_OFS_IRQ_MASK: rd_mux[`AFB_IRQ_W-1:0] = irq_mask;
      default: rd_mux = 16'h0000;
    endcase
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 16'h0000;
    else if (reg_read)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= 16'h0000;
  end

endmodule // afb_bank

// file: tb/afb_far_end.sv
// far-side model: comm unit pins, network results, inner board codes
// assumes the bench calls its tasks; outputs move just after clk rises
`timescale 1ns/1ps
module afb_far_end (
  // clock
  input wire clk,
  // comm unit levels
  output logic error_pin,
  output logic mounted_pin,
  output logic busy_pin,
  // network results
  output logic net_done,
  output logic net_failed,
  output logic [7:0] net_code,
  output logic net_ready,
  // inner boards
  output logic [7:0] slot1,
  output logic [7:0] slot2
);
  initial
  begin
    {error_pin, mounted_pin, busy_pin, net_done, net_failed, net_ready} = 6'h00;
    {net_code, slot1, slot2} = 24'h000000;
  end
  task set_levels(input logic e, m, r, input logic [7:0] s1, s2);
    @(posedge clk);
    error_pin <= e;
    mounted_pin <= m;
    net_ready <= r;
    slot1 <= s1;
    slot2 <= s2;
  endtask
  // code lines show junk once released, never a stale value
  task net_op(input logic [7:0] c, input logic f);
    @(posedge clk);
    net_done <= 1'b1;
    net_failed <= f;
    net_code <= c;
    @(posedge clk);
    net_done <= 1'b0;
    net_failed <= ~f;
    net_code <= ~c;
  endtask
  task serve(input int n);
    @(posedge clk);
    busy_pin <= 1'b1;
    repeat (n) @(posedge clk);
    busy_pin <= 1'b0;
  endtask
endmodule // afb_far_end

// file: tb/afb_props.sv
// port assertions for the flag word bank
// assumes one clock domain, reset_n active low asynchronous
`timescale 1ns/1ps
module afb_props #(
  parameter [14:0] SVC_CYCLES = 15'd4
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // register port
  input wire [3:0] reg_addr,
  input wire reg_read,
  input wire [15:0] reg_rdata,
  // scan and control
  input wire scan_tick,
  input wire [3:0] counter_sw_only,
  input wire comm_restart,
  input wire special_comm_error,
  input wire [3:0] counter_index_reset_en,
  input wire [3:0] counter_sw_reset,
  input wire [3:0] compare_start,
  input wire [3:0] compare_stop,
  input wire [3:0] counter_halt,
  input wire [3:0] ext_force_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_read_idle_zero: assert property (!reg_read |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside answer");
  a_unmapped_read: assert property (reg_read && reg_addr > 4'h8 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_error_mirror: assert property (reg_read && reg_addr == 4'h0
    |=> reg_rdata[11] == $past(special_comm_error)) else $error("error flag copy differs");
  a_ctrl_hold: assert property (!scan_tick
    |=> $stable({counter_halt, ext_force_on, counter_index_reset_en}))
    else $error("control output moved without scan");
  a_pulse_at_scan: assert property (|{comm_restart, counter_sw_reset,
    compare_start, compare_stop} |-> $past(scan_tick)) else $error("pulse without scan");
  a_start_stop_excl: assert property ((compare_start & compare_stop) == 4'h0)
    else $error("start and stop together");
  a_restart_single: assert property (comm_restart |=> !comm_restart)
    else $error("restart longer than one cycle");
  a_index_mode: assert property (scan_tick
    |=> (counter_index_reset_en & $past(counter_sw_only)) == 4'h0)
    else $error("index reset enabled in software mode");
  a_soft_mode: assert property (scan_tick
    |=> (counter_sw_reset & ~$past(counter_sw_only)) == 4'h0)
    else $error("software reset in combined mode");
  c_restart: cover property (comm_restart);
  c_stop: cover property (|compare_stop);
  c_swreset: cover property (|counter_sw_reset);
  c_force: cover property (|ext_force_on);
endmodule // afb_props
bind afb_bank afb_props #(.SVC_CYCLES(SVC_CYCLES)) u_props (.clk(clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata), .scan_tick(scan_tick),
  .counter_sw_only(counter_sw_only), .comm_restart(comm_restart),
  .special_comm_error(special_comm_error), .counter_index_reset_en(counter_index_reset_en),
  .counter_sw_reset(counter_sw_reset), .compare_start(compare_start),
  .compare_stop(compare_stop), .counter_halt(counter_halt), .ext_force_on(ext_force_on));

// file: tb/tb_top.sv
// self-checking bench for the flag word bank
// assumes 200 MHz clk and a servicing unit shortened to 4 cycles
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
  logic clk, reset_n, reg_write, reg_read, scan_tick, restart;
  logic [3:0] reg_addr, sw_only, idx, swr, cs, cp, halt, force_on;
  logic [15:0] reg_wdata, reg_rdata;
  logic e, m, b, nd, nf, nr, spec, irq;
  logic [7:0] nc, s1, s2;
  logic [39:0] r;
  int n_errors = 0, checked = 0;
  // addr, data, sw_only, halt, force, index enable, software reset
  logic [39:0] rows [5] = '{40'h5500305030, 40'h6001f05f30, 40'h6000f05030,
    40'h5a00cca00c, 40'h60015ca500};
  afb_far_end far (.clk(clk), .error_pin(e), .mounted_pin(m), .busy_pin(b), .net_done(nd),
    .net_failed(nf), .net_code(nc), .net_ready(nr), .slot1(s1), .slot2(s2));
  afb_bank #(.SVC_CYCLES(15'd4)) uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .scan_tick(scan_tick), .comm_error_pin(e), .comm_mounted_pin(m),
    .comm_busy_pin(b), .comm_restart(restart), .special_comm_error(spec), .net_done(nd),
    .net_failed(nf), .net_code(nc), .net_ready(nr), .slot1_code(s1), .slot2_code(s2),
    .counter_sw_only(sw_only), .counter_index_reset_en(idx), .counter_sw_reset(swr),
    .compare_start(cs), .compare_stop(cp), .counter_halt(halt), .ext_force_on(force_on),
    .irq(irq));
  task end_of_test;
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] x);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 `CHK("rdata", x, reg_rdata)
  endtask
  // outputs and pulses are looked at in the cycle after the scan edge
  task tick;
    @(posedge clk);
    scan_tick <= 1'b1;
    @(posedge clk);
    scan_tick <= 1'b0;
    #1;
  endtask
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #100000 n_errors++;
    end_of_test;
  end
  initial
  begin
    {reset_n, reg_write, reg_read, scan_tick, reg_addr, sw_only} = 12'h000;
    reg_wdata = 16'h0000;
    repeat (3) @(posedge clk);
    #1 `CHK("reset out", 9'h000, {halt, force_on, irq})
    reset_n <= 1'b1;
    foreach (rows[i])
    begin
      r = rows[i];
      sw_only <= r[19:16];
      wr(r[39:36], r[35:20]);
      tick;
      `CHK("halt", r[15:12], halt)
      `CHK("force", r[11:8], force_on)
      `CHK("index", r[7:4], idx)
      `CHK("swreset", r[3:0], swr)
    end
    wr(4'h5, 16'hffff);
    rd(4'h5, 16'hff0f);
    tick;
    `CHK("start", 4'hf, cs)
    wr(4'h5, 16'h0000);
    tick;
    `CHK("stop", 4'hf, cp)
    wr(4'h1, 16'hffff);
    rd(4'h1, 16'h0800);
    tick;
    wr(4'h1, 16'h0000);
    tick;
    `CHK("restart", 1'b1, restart)
    far.serve(40);
    far.set_levels(1'b1, 1'b1, 1'b1, 8'h04, 8'h03);
    far.net_op(8'h5a, 1'b1);
    repeat (4) @(posedge clk);
    wr(4'h0, 16'h0000);
    tick;
    `CHK("special", 1'b1, spec)
    rd(4'h0, 16'h0800);
    rd(4'h2, 16'h835a);
    rd(4'h3, 16'h0010);
    rd(4'h4, 16'h0304);
    rd(4'h7, 16'h001f);
    rd(4'hc, 16'h0000);
    `CHK("irq masked", 1'b0, irq)
    wr(4'h8, 16'h001f);
    @(posedge clk);
    #1 `CHK("irq on", 1'b1, irq)
    wr(4'h7, 16'h001f);
    repeat (2) @(posedge clk);
    #1 `CHK("irq off", 1'b0, irq)
    rd(4'h7, 16'h0000);
    end_of_test;
  end
endmodule // tb_top
